// file: pio_pkg.sv
package pio_pkg;

  // Bus widths
  localparam int BUS_W        = 16;
  localparam int BYTE_W       = 8;
  // Device code lies on lines 8..15 during an address cycle
  localparam int CODE_LSB     = 8;
  // Interrupt mode field inside a command halfword
  localparam int IMODE_LSB    = 8;
  localparam logic [7:0] CODE_MIN = 8'h01;
  localparam logic [7:0] CODE_MAX = 8'hFF;

  // Bus timing, ns, as printed
  localparam int CLK_PERIOD_NS    = 5;
  localparam int T_SETUP_NS       = 100;  // data before strobe, least
  localparam int T_HOLD_NS        = 100;  // data after strobe removal, least
  localparam int T_ACK_RELEASE_NS = 130;  // ack removal after strobe removal, most
  localparam int T_ACK_MIN_NS     = 100;  // strobe held after ack seen, least
  localparam int T_TIMEOUT_NS     = 20000;

  // Least times round up, longest times round down
  localparam logic [11:0] SETUP_CYC   = 12'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] HOLD_CYC    = 12'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ACKHOLD_CYC = 12'((T_ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] TIMEOUT_CYC = 12'(T_TIMEOUT_NS / CLK_PERIOD_NS);

  // Transfer kinds requested by the user side
  typedef enum logic [2:0] {
    PIO_OP_ADDRESS = 3'b000,
    PIO_OP_COMMAND = 3'b001,
    PIO_OP_WDATA   = 3'b010,
    PIO_OP_RDATA   = 3'b011,
    PIO_OP_STATUS  = 3'b100,
    PIO_OP_RACK    = 3'b101
  } pio_op_type;

  // Interrupt mode command codes
  localparam logic [1:0] IMODE_KEEP    = 2'b00;
  localparam logic [1:0] IMODE_ENABLE  = 2'b01;
  localparam logic [1:0] IMODE_DISABLE = 2'b10;
  localparam logic [1:0] IMODE_DISARM  = 2'b11;

endpackage

// file: pio_sync_if.sv
`timescale 1ns/1ps
interface pio_sync_if;
  logic        ack_raw_n;
  logic [15:0] data_raw_n;
  logic        ack;
  logic [15:0] data;
  modport src (input ack, input data, output ack_raw_n, output data_raw_n);
  modport syn (input ack_raw_n, input data_raw_n, output ack, output data);
endinterface

// file: pio_sync.sv
`timescale 1ns/1ps
module pio_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Raw pins in, true-level samples out
  pio_sync_if.syn  sig
);

  logic [16:0] stage1;
  logic [16:0] stage2;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1 <= 17'h1FFFF;
      stage2 <= 17'h1FFFF;
    end else begin
      stage1 <= {sig.ack_raw_n, sig.data_raw_n};
      stage2 <= stage1;
    end
  end

  // Bus is active low; invert after the second stage only
  assign sig.ack  = ~stage2[16];
  assign sig.data = ~stage2[15:0];

endmodule // pio_sync

// file: pio_host.sv
`timescale 1ns/1ps
module pio_host #(
  parameter bit BYTE_ONLY = 1'b0
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // User request
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_op,
  input  wire logic [15:0] req_data,
  output logic             req_ready,
  // User answer
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             rsp_timeout,
  output logic             selected,
  output logic [1:0]       imode_shadow,
  // Device bus pins, active low except bus_data_oe
  input  wire logic [15:0] bus_data_in_n,
  output logic [15:0]      bus_data_out_n,
  output logic             bus_data_oe,
  input  wire logic        bus_transfer_ack_n,
  output logic             address_strobe_n,
  output logic             cmd_strobe_n,
  output logic             data_avail_n,
  output logic             data_req_n,
  output logic             status_req_n,
  output logic             rack_n
);

  typedef enum logic [2:0] {
    PIO_ST_IDLE  = 3'b000,
    PIO_ST_SETUP = 3'b001,
    PIO_ST_WAIT  = 3'b010,
    PIO_ST_HOLDS = 3'b011,
    PIO_ST_DROP  = 3'b100,
    PIO_ST_HOLDD = 3'b101
  } pio_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser

  // Data lines share the ack's two flops, so read data is never older than ack
  pio_sync_if sync_bus ();
  assign sync_bus.ack_raw_n  = bus_transfer_ack_n;
  assign sync_bus.data_raw_n = bus_data_in_n;

  pio_sync u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .sig      (sync_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic is_output(input logic [2:0] op);
    return op == pio_pkg::PIO_OP_ADDRESS || op == pio_pkg::PIO_OP_COMMAND ||
           op == pio_pkg::PIO_OP_WDATA;
  endfunction

  pio_state_type state;
  pio_state_type next_state;
  logic [2:0]    op;
  logic [15:0]   wdata;
  logic [11:0]   cnt;
  logic          strobe_on;

  wire ack_seen  = sync_bus.ack;
  wire cnt_done  = (cnt == 12'h000);
  // Bound the wait so an absent device cannot hang the port
  wire timed_out = (cnt == pio_pkg::TIMEOUT_CYC);
  wire op_out    = is_output(op);
  wire [15:0] rd_data = BYTE_ONLY || op == pio_pkg::PIO_OP_STATUS ||
                        op == pio_pkg::PIO_OP_RACK
                        ? {8'h00, sync_bus.data[7:0]} : sync_bus.data;

  wire [15:0] shaped =
    req_op == pio_pkg::PIO_OP_ADDRESS ? {req_data[7:0], 8'h00} :
    (BYTE_ONLY && req_op == pio_pkg::PIO_OP_WDATA) ? {8'h00, req_data[7:0]} :
    req_data;

  wire code_ok = req_op != pio_pkg::PIO_OP_ADDRESS || req_data[7:0] >= pio_pkg::CODE_MIN;
  // Taken only when ready, so a request right after reset waits its turn
  wire take    = state == PIO_ST_IDLE && req_valid && req_ready && code_ok;

  always_comb begin
    next_state = state;
    case (state)
      PIO_ST_IDLE: begin
        if (take)
          next_state = PIO_ST_SETUP;
      end
      PIO_ST_SETUP: begin
        if (cnt_done)
          next_state = PIO_ST_WAIT;
      end
      PIO_ST_WAIT: begin
        if (ack_seen || timed_out)
          next_state = ack_seen ? PIO_ST_HOLDS : PIO_ST_DROP;
      end
      PIO_ST_HOLDS: begin
        if (cnt_done)
          next_state = PIO_ST_DROP;
      end
      PIO_ST_DROP: begin
        next_state = PIO_ST_HOLDD;
      end
      PIO_ST_HOLDD: begin
        // Hold the data until the device has dropped its acknowledge
        if (cnt_done && !ack_seen)
          next_state = PIO_ST_IDLE;
      end
      // Unused codes fall back to idle
      default: next_state = PIO_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= PIO_ST_IDLE;
      op    <= 3'h0;
      wdata <= 16'h0000;
      cnt   <= 12'h000;
    end else begin
      state <= next_state;
      // One counter serves setup, timeout, strobe hold and data hold
      if (take) begin
        op    <= req_op;
        wdata <= shaped;
        // Input requests need no setup of our own data
        cnt   <= is_output(req_op) ? pio_pkg::SETUP_CYC - 12'h001 : 12'h000;
      end else if (state == PIO_ST_WAIT) begin
        cnt <= ack_seen ? pio_pkg::ACKHOLD_CYC - 12'h001 : cnt + 12'h001;
      end else if (next_state == PIO_ST_HOLDD && state == PIO_ST_DROP) begin
        cnt <= pio_pkg::HOLD_CYC - 12'h001;
      end else if (!cnt_done && state != PIO_ST_IDLE) begin
        cnt <= cnt - 12'h001;
      end
    end
  end

  assign strobe_on = (state == PIO_ST_WAIT) || (state == PIO_ST_HOLDS);

  ////////////////////////////////////////////////////////////////////////////
  // Pins and answers

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_data_out_n   <= 16'hFFFF;
      bus_data_oe      <= 1'b0;
      address_strobe_n <= 1'b1;
      cmd_strobe_n     <= 1'b1;
      data_avail_n     <= 1'b1;
      data_req_n       <= 1'b1;
      status_req_n     <= 1'b1;
      rack_n           <= 1'b1;
      req_ready        <= 1'b0;
      rsp_valid        <= 1'b0;
      rsp_data         <= 16'h0000;
      rsp_timeout      <= 1'b0;
      selected         <= 1'b0;
      imode_shadow     <= pio_pkg::IMODE_DISARM;
    end else begin
      bus_data_out_n   <= ~wdata;
      bus_data_oe      <= op_out && state != PIO_ST_IDLE;
      address_strobe_n <= ~(strobe_on && op == pio_pkg::PIO_OP_ADDRESS);
      cmd_strobe_n     <= ~(strobe_on && op == pio_pkg::PIO_OP_COMMAND);
      data_avail_n     <= ~(strobe_on && op == pio_pkg::PIO_OP_WDATA);
      data_req_n       <= ~(strobe_on && op == pio_pkg::PIO_OP_RDATA);
      status_req_n     <= ~(strobe_on && op == pio_pkg::PIO_OP_STATUS);
      rack_n           <= ~(strobe_on && op == pio_pkg::PIO_OP_RACK);
      // Ready only once the bus has gone quiet, so transfers never overlap
      req_ready        <= next_state == PIO_ST_IDLE && state != PIO_ST_SETUP;
      rsp_valid        <= 1'b0;
      if (state == PIO_ST_WAIT && (ack_seen || timed_out)) begin
        rsp_valid   <= 1'b1;
        rsp_timeout <= !ack_seen;
        rsp_data    <= op_out ? 16'h0000 : rd_data;
        if (op == pio_pkg::PIO_OP_ADDRESS)
          selected <= ack_seen;
        if (op == pio_pkg::PIO_OP_COMMAND && ack_seen && selected &&
            wdata[pio_pkg::IMODE_LSB +: 2] != pio_pkg::IMODE_KEEP)
          imode_shadow <= wdata[pio_pkg::IMODE_LSB +: 2];
      end
    end
  end

endmodule // pio_host

// file: pio_host_monitor.sv
`timescale 1ns/1ps
module pio_host_monitor (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // Bus pins
  input wire logic [15:0] bus_data_out_n,
  input wire logic        bus_data_oe,
  input wire logic        address_strobe_n,
  input wire logic        cmd_strobe_n,
  input wire logic        data_avail_n,
  input wire logic        data_req_n,
  input wire logic        status_req_n,
  input wire logic        rack_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_addr_drive;
    !address_strobe_n |-> bus_data_oe && $stable(bus_data_out_n);
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("address code moved under strobe");
  property p_in_release;
    !(data_req_n && status_req_n && rack_n) |-> !bus_data_oe;
  endproperty
  a_in_release: assert property (p_in_release)
    else $error("host drives bus during a read");
  property p_one_strobe;
    $countones({address_strobe_n, cmd_strobe_n, data_avail_n,
                data_req_n, status_req_n, rack_n}) >= 5;
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("two strobes low at once");
  property p_setup;
    ($fell(address_strobe_n) || $fell(cmd_strobe_n) || $fell(data_avail_n))
      |-> $past(bus_data_oe, 20) && $past(bus_data_oe);
  endproperty
  a_setup: assert property (p_setup)
    else $error("write strobe without data setup");
endmodule // pio_host_monitor

// file: pio_dev_model.sv
`timescale 1ns/1ps
module pio_dev_model #(
  parameter logic [7:0] DEV_CODE = 8'h5A
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Ack delay, cycles
  input  wire logic [7:0]  lag,
  // Host pins; strobes are addr, cmd, wdata, rdata, status, rack
  input  wire logic [15:0] host_out_n,
  input  wire logic        host_oe,
  input  wire logic [5:0]  strobe_n,
  output logic             ack_n,
  output logic [15:0]      bus_n
);
  logic [15:0] word;
  logic [1:0]  imode;
  logic        sel;
  logic [7:0]  cnt;
  logic [5:0]  prev_n;
  logic [15:0] drv_n;
  wire match = (~bus_n[15:8] == DEV_CODE);
  wire want = (!strobe_n[5] && match) || (!(&strobe_n[4:0]) && sel);
  wire m_oe = sel && !(&strobe_n[2:0]);
  assign ack_n = !(want && cnt >= lag);
  assign drv_n = !strobe_n[2] ? ~word :
                 !strobe_n[1] ? {~cnt, ~{6'h00, imode}} : {~cnt, ~DEV_CODE};
  assign bus_n = host_oe ? host_out_n : (m_oe ? drv_n : 16'hFFFF);
  always @(posedge core_clk) begin
    prev_n <= strobe_n;
    cnt <= want ? cnt + 8'h01 : 8'h00;
    if (srst) begin
      sel <= 1'b0;
      imode <= 2'h3;
    end else begin
      if (strobe_n[5] && !prev_n[5]) sel <= match;
      if (strobe_n[3] && !prev_n[3] && sel) word <= ~bus_n;
      if (strobe_n[4] && !prev_n[4] && sel && ~bus_n[9:8] != 2'h0) imode <= ~bus_n[9:8];
    end
  end
endmodule // pio_dev_model

// file: pio_host_test.sv
`timescale 1ns/1ps
module pio_host_test;
  localparam logic [7:0] DEV_CODE = 8'h5A;
  logic core_clk = 0, srst = 1, req_valid = 0, req_ready, rsp_valid, rsp_timeout, selected;
  logic [2:0] req_op = 0;
  logic [15:0] req_data = 0, rsp_data, out_n, wd;
  logic [1:0] imode_shadow, mode;
  logic [7:0] lag = 0, c;
  logic oe;
  wire ack_n;
  wire [15:0] bus_n;
  wire [5:0] stb_n;
  logic rdy_b, vld_b, to_b, sel_b, oe_b;
  logic [15:0] rsp_b, out_b;
  logic [1:0] im_b;
  wire ack_b_n;
  wire [15:0] bus_b_n;
  wire [5:0] stb_b_n;
  logic [1:0] seq [5] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1};
  int err_total = 0, samples_checked = 0, cyc = 0;
  pio_host dut (.core_clk(core_clk), .srst(srst), .req_valid(req_valid), .req_op(req_op),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_timeout(rsp_timeout), .selected(selected), .imode_shadow(imode_shadow),
    .bus_data_in_n(bus_n), .bus_data_out_n(out_n), .bus_data_oe(oe),
    .bus_transfer_ack_n(ack_n), .address_strobe_n(stb_n[5]), .cmd_strobe_n(stb_n[4]),
    .data_avail_n(stb_n[3]), .data_req_n(stb_n[2]), .status_req_n(stb_n[1]), .rack_n(stb_n[0]));
  pio_dev_model #(.DEV_CODE(DEV_CODE)) u_dev (.core_clk(core_clk), .srst(srst), .lag(lag),
    .host_out_n(out_n), .host_oe(oe), .strobe_n(stb_n), .ack_n(ack_n), .bus_n(bus_n));
  // Byte variant runs in lockstep with the halfword one
  pio_host #(.BYTE_ONLY(1'b1)) dut_byte (.core_clk(core_clk), .srst(srst),
    .req_valid(req_valid), .req_op(req_op), .req_data(req_data), .req_ready(rdy_b),
    .rsp_valid(vld_b), .rsp_data(rsp_b), .rsp_timeout(to_b), .selected(sel_b),
    .imode_shadow(im_b), .bus_data_in_n(bus_b_n), .bus_data_out_n(out_b), .bus_data_oe(oe_b),
    .bus_transfer_ack_n(ack_b_n), .address_strobe_n(stb_b_n[5]), .cmd_strobe_n(stb_b_n[4]),
    .data_avail_n(stb_b_n[3]), .data_req_n(stb_b_n[2]), .status_req_n(stb_b_n[1]),
    .rack_n(stb_b_n[0]));
  pio_dev_model #(.DEV_CODE(DEV_CODE)) u_dev_b (.core_clk(core_clk), .srst(srst), .lag(lag),
    .host_out_n(out_b), .host_oe(oe_b), .strobe_n(stb_b_n), .ack_n(ack_b_n), .bus_n(bus_b_n));
  ////////////////////////////////////////
  function automatic logic [1:0] next_mode(input logic [1:0] cur, input logic [1:0] cmd);
    return (cmd == pio_pkg::IMODE_KEEP) ? cur : cmd;
  endfunction
  task close_out;
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Ack delay changes only after take, never under a live strobe
  task xfer(input pio_pkg::pio_op_type op, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    #1 req_valid = 1;
    req_op = op;
    req_data = d;
    do begin @(posedge core_clk); n++; end while (req_ready !== 1'b1 && n < 9000);
    #1 req_valid = 0;
    lag = 8'($urandom_range(0, 40));
    n = 0;
    while (rsp_valid !== 1'b1 && n < 9000) begin @(posedge core_clk); #1 n++; end
    if (rsp_valid !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t no answer", $time);
    end
  endtask
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("[ERR] %0t watchdog", $time);
      close_out();
    end
  end
  initial begin
    void'($urandom(32'hB5C0));
    repeat (4) @(posedge core_clk);
    #1 srst = 0;
    c = 8'($urandom_range(1, 255));
    if (c == DEV_CODE) c = c ^ 8'h01;
    xfer(pio_pkg::PIO_OP_ADDRESS, {8'h00, c});
    chk({15'h0, rsp_timeout}, 16'h0001);
    chk({15'h0, selected}, 16'h0000);
    xfer(pio_pkg::PIO_OP_ADDRESS, {8'h00, DEV_CODE});
    chk({15'h0, selected}, 16'h0001);
    xfer(pio_pkg::PIO_OP_STATUS, 16'h0000);
    chk(rsp_data, 16'h0003);
    chk({15'h0, rsp_timeout}, 16'h0000);
    xfer(pio_pkg::PIO_OP_RACK, 16'h0000);
    chk(rsp_data, {8'h00, DEV_CODE});
    mode = pio_pkg::IMODE_DISARM;
    for (int i = 0; i < 5; i++) begin
      xfer(pio_pkg::PIO_OP_COMMAND, {6'($urandom), seq[i], 8'($urandom)});
      mode = next_mode(mode, seq[i]);
      xfer(pio_pkg::PIO_OP_STATUS, 16'h0000);
      chk(rsp_data, {14'h0, mode});
      chk({14'h0, imode_shadow}, {14'h0, mode});
      chk({14'h0, im_b}, {14'h0, mode});
    end
    for (int i = 0; i < 4; i++) begin
      wd = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
      xfer(pio_pkg::PIO_OP_WDATA, wd);
      chk(rsp_data, 16'h0000);
      xfer(pio_pkg::PIO_OP_RDATA, 16'h0000);
      chk(rsp_data, wd);
      chk(rsp_b, {8'h00, wd[7:0]});
      chk({12'h0, rdy_b, vld_b, to_b, sel_b}, 16'h0005);
    end
    xfer(pio_pkg::PIO_OP_ADDRESS, {8'h00, c});
    chk({15'h0, selected}, 16'h0000);
    xfer(pio_pkg::PIO_OP_RDATA, 16'h0000);
    chk({15'h0, rsp_timeout}, 16'h0001);
    // Code zero must never start a cycle
    @(posedge core_clk);
    #1 req_valid = 1;
    req_op = pio_pkg::PIO_OP_ADDRESS;
    req_data = 16'h0000;
    repeat (40) @(posedge core_clk);
    #1 req_valid = 0;
    chk({14'h0, stb_n[5], req_ready}, 16'h0003);
    close_out();
  end
endmodule // pio_host_test
bind pio_host pio_host_monitor u_mon (.core_clk(core_clk), .srst(srst),
  .bus_data_out_n(bus_data_out_n), .bus_data_oe(bus_data_oe),
  .address_strobe_n(address_strobe_n), .cmd_strobe_n(cmd_strobe_n),
  .data_avail_n(data_avail_n), .data_req_n(data_req_n), .status_req_n(status_req_n),
  .rack_n(rack_n));
